// ==== logic/psr_top.sv ====
// psr_top: pll readback status register behind an AHB-Lite slave, with monitor select and irq
// assumes status sources are asynchronous levels from loop, monitors and switchover logic
//
// Function
// - bit 4 shows which reference drives loop
// - differential mode forces bit 4 to zero
// - bit 3 high while oscillator above threshold
// - bit 2 tracks second reference above threshold
// - bit 1 tracks first reference above threshold
// - config bit 6 picks the shared threshold
// - bit 0 shows digital lock detect result
// - bit 5 high only while holdover active
`timescale 1ns/1ps
`default_nettype none

module psr_top #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic      [31:0]              hrdata,
  output logic                          hreadyout,
  output logic      [1:0]               hresp,
  input  wire logic                     lock_detect,
  input  wire logic                     first_ref_above_lo,
  input  wire logic                     first_ref_above_hi,
  input  wire logic                     second_ref_above_lo,
  input  wire logic                     second_ref_above_hi,
  input  wire logic                     osc_above_threshold,
  input  wire logic                     second_input_chosen,
  input  wire logic                     differential_mode,
  input  wire logic                     holdover_active,
  input  wire logic                     calibration_done,
  output logic                          threshold_select,
  output logic                          irq
);

  initial begin
    if (SYNC_STAGES < 2) begin
      $error("psr_top: SYNC_STAGES must be at least 2");
    end
  end

  // synchroniser chain; stage 0 only feeds stage 1
  psr_pkg::psr_mon_type                         mon_raw;
  logic [SYNC_STAGES-1:0][psr_pkg::MON_W-1:0]  sync_reg;
  psr_pkg::psr_mon_type                         mon;

  assign mon_raw = '{cal_done: calibration_done, holdover: holdover_active,
                     diff_mode: differential_mode, second_input_chosen: second_input_chosen,
                     osc_high: osc_above_threshold, second_above_hi: second_ref_above_hi,
                     second_above_lo: second_ref_above_lo, first_above_hi: first_ref_above_hi,
                     first_above_lo: first_ref_above_lo, lock: lock_detect};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[SYNC_STAGES-2:0], mon_raw};
    end
  end

  assign mon = psr_pkg::psr_mon_type'(sync_reg[SYNC_STAGES-1]);

  // bus request capture
  psr_pkg::psr_ahb_req_type req;
  logic                     req_take;
  logic                     rd_take;
  logic                     wr_take;

  assign req = '{sel: hsel, addr: haddr[psr_pkg::ADDR_BITS-1:0], trans: htrans,
                 write: hwrite, size: hsize, ready: hready};
  assign req_take = req.sel && req.trans[1] && req.ready;
  assign rd_take  = req_take && !req.write;
  assign wr_take  = req_take && req.write;

  // live status composition
  logic [7:0] moncfg_reg;
  logic [7:0] moncfg_next;
  logic       thr_hi;
  logic [7:0] status_live;

  assign thr_hi = moncfg_reg[psr_pkg::THRESH_SEL_BIT];
  assign status_live[7] = 1'b0;
  assign status_live[psr_pkg::STS_CAL_BIT]  = mon.cal_done;
  assign status_live[psr_pkg::STS_HOLD_BIT] = mon.holdover;
  // differential pairs read as the first input
  assign status_live[psr_pkg::STS_SEL_BIT]  = mon.second_input_chosen && !mon.diff_mode;
  assign status_live[psr_pkg::STS_OSC_BIT]  = mon.osc_high;
  // one shared threshold for both monitors
  assign status_live[psr_pkg::STS_SECOND_BIT] = thr_hi ? mon.second_above_hi
                                                       : mon.second_above_lo;
  assign status_live[psr_pkg::STS_FIRST_BIT]  = thr_hi ? mon.first_above_hi
                                                       : mon.first_above_lo;
  assign status_live[psr_pkg::STS_LOCK_BIT] = mon.lock;

  // write data phase
  logic                         wr_pend_reg;
  logic [psr_pkg::ADDR_BITS-1:0] wr_addr_reg;
  logic                         wr_moncfg;
  logic                         wr_ena;
  logic                         wr_clr;

  assign wr_moncfg = wr_pend_reg && (wr_addr_reg == psr_pkg::MONCFG_ADDR);
  assign wr_ena    = wr_pend_reg && (wr_addr_reg == psr_pkg::IRQ_ENA_ADDR);
  assign wr_clr    = wr_pend_reg && (wr_addr_reg == psr_pkg::IRQ_CLR_ADDR);
  // no write path exists for the status word
  assign moncfg_next = wr_moncfg ? hwdata[7:0] : moncfg_reg;

  // interrupt events from edges of the synced status
  logic [7:0]                   status_prev_reg;
  logic [psr_pkg::IRQ_BITS-1:0] events;
  logic [psr_pkg::IRQ_BITS-1:0] irq_sts_reg;
  logic [psr_pkg::IRQ_BITS-1:0] irq_sts_next;
  logic [psr_pkg::IRQ_BITS-1:0] irq_ena_reg;
  logic [psr_pkg::IRQ_BITS-1:0] irq_ena_next;
  logic [psr_pkg::IRQ_BITS-1:0] clr_mask;

  assign events[psr_pkg::EV_LOCK_LOST] = status_prev_reg[psr_pkg::STS_LOCK_BIT]
                                         && !status_live[psr_pkg::STS_LOCK_BIT];
  assign events[psr_pkg::EV_LOCK_GOT]  = !status_prev_reg[psr_pkg::STS_LOCK_BIT]
                                         && status_live[psr_pkg::STS_LOCK_BIT];
  assign events[psr_pkg::EV_REF_SWAP]  = status_prev_reg[psr_pkg::STS_SEL_BIT]
                                         != status_live[psr_pkg::STS_SEL_BIT];
  assign events[psr_pkg::EV_HOLD_IN]   = !status_prev_reg[psr_pkg::STS_HOLD_BIT]
                                         && status_live[psr_pkg::STS_HOLD_BIT];
  assign clr_mask     = wr_clr ? hwdata[psr_pkg::IRQ_BITS-1:0] : psr_pkg::IRQ_RESET;
  // set wins over a clear in the same cycle
  assign irq_sts_next = (irq_sts_reg & ~clr_mask) | events;
  assign irq_ena_next = wr_ena ? hwdata[psr_pkg::IRQ_BITS-1:0] : irq_ena_reg;

  // read mux, captured in the address phase so hrdata comes from a flop
  logic [31:0] rd_mux;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  assign rd_mux = (req.addr == psr_pkg::STATUS_ADDR)  ? {24'h00_0000, status_live} :
                  (req.addr == psr_pkg::MONCFG_ADDR)  ? {24'h00_0000, moncfg_reg} :
                  (req.addr == psr_pkg::IRQ_STS_ADDR) ? {28'h000_0000, irq_sts_reg} :
                  (req.addr == psr_pkg::IRQ_ENA_ADDR) ? {28'h000_0000, irq_ena_reg} :
                  psr_pkg::ZERO_WORD;
  assign hrdata_next = rd_take ? rd_mux : hrdata_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg  <= psr_pkg::ZERO_WORD;
    end else begin
      wr_pend_reg <= wr_take;
      wr_addr_reg <= req.addr;
      hrdata_reg  <= hrdata_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      moncfg_reg      <= psr_pkg::MONCFG_RESET;
      status_prev_reg <= 8'h00;
      irq_sts_reg     <= psr_pkg::IRQ_RESET;
      irq_ena_reg     <= psr_pkg::IRQ_RESET;
    end else begin
      moncfg_reg      <= moncfg_next;
      status_prev_reg <= status_live;
      irq_sts_reg     <= irq_sts_next;
      irq_ena_reg     <= irq_ena_next;
    end
  end

  // zero wait states keep the slave trivially compliant
  assign hreadyout        = 1'b1;
  assign hresp            = psr_pkg::HRESP_OKAY;
  assign hrdata           = hrdata_reg;
  assign threshold_select = thr_hi;
  assign irq              = |(irq_sts_reg & irq_ena_reg);

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sel_diff_zero_a: assert property (
    rd_take && req.addr == psr_pkg::STATUS_ADDR && mon.diff_mode
    |=> !hrdata[psr_pkg::STS_SEL_BIT])
    else $error("ref select bit set in differential mode");

  sel_second_a: assert property (
    $rose(sync_reg[SYNC_STAGES-1][6]) && !mon.diff_mode
    |-> status_live[psr_pkg::STS_SEL_BIT])
    else $error("ref select bit missed second input");

  sync_lock_a: assert property (
    $stable(lock_detect)[*3] ##0 1'b1 |-> status_live[psr_pkg::STS_LOCK_BIT] == $past(lock_detect, 2))
    else $error("lock bit does not follow lock detect");

  osc_bit_a: assert property (
    rd_take && req.addr == psr_pkg::STATUS_ADDR
    |=> hrdata[psr_pkg::STS_OSC_BIT] == $past(mon.osc_high))
    else $error("oscillator bit wrong on read");

  second_thresh_a: assert property (
    thr_hi |-> status_live[psr_pkg::STS_SECOND_BIT] == mon.second_above_hi)
    else $error("second reference used wrong threshold");

  first_thresh_a: assert property (
    !thr_hi |-> status_live[psr_pkg::STS_FIRST_BIT] == mon.first_above_lo)
    else $error("first reference used wrong threshold");

  thresh_write_a: assert property (
    wr_moncfg |=> threshold_select == $past(hwdata[psr_pkg::THRESH_SEL_BIT]))
    else $error("threshold select not taken from write");

  hold_bit_a: assert property (
    $rose(status_live[psr_pkg::STS_HOLD_BIT])
    |=> irq_sts_reg[psr_pkg::EV_HOLD_IN])
    else $error("holdover entry not recorded");

  status_write_a: assert property (
    wr_pend_reg && wr_addr_reg == psr_pkg::STATUS_ADDR |=> $stable(moncfg_reg) && $stable(irq_ena_reg))
    else $error("status write changed state");

  set_wins_a: assert property (
    wr_clr && events[psr_pkg::EV_LOCK_LOST] |=> irq_sts_reg[psr_pkg::EV_LOCK_LOST])
    else $error("clear beat a new event");

  irq_level_a: assert property (
    irq == |(irq_sts_reg & irq_ena_reg) && hreadyout && hresp == psr_pkg::HRESP_OKAY)
    else $error("irq or bus response wrong");

  status_read_c: cover property (rd_take && req.addr == psr_pkg::STATUS_ADDR);
  lock_lost_c:   cover property (events[psr_pkg::EV_LOCK_LOST] ##[1:20] irq);
  thresh_flip_c: cover property (wr_moncfg ##1 $changed(threshold_select));
  clr_event_c:   cover property (wr_clr && |events);

endmodule : psr_top

`default_nettype wire

// ==== logic/psr_pkg.sv ====
// psr_pkg: register map, field positions and carrier types of the pll status readback block
// assumes byte addressing on a 32-bit AHB-Lite bus, one register per aligned word
package psr_pkg;

  localparam int unsigned ADDR_BITS  = 12;
  localparam int unsigned WORD_SHIFT = 2;
  localparam int unsigned IRQ_BITS   = 4;

  // printed offsets are register indices; byte address is four times the index
  localparam logic [ADDR_BITS-1:0] STATUS_INDEX = 12'h01F;
  localparam logic [ADDR_BITS-1:0] MONCFG_INDEX = 12'h01A;
  localparam logic [ADDR_BITS-1:0] STATUS_ADDR  = STATUS_INDEX << WORD_SHIFT;
  localparam logic [ADDR_BITS-1:0] MONCFG_ADDR  = MONCFG_INDEX << WORD_SHIFT;
  localparam logic [ADDR_BITS-1:0] IRQ_STS_ADDR = 12'h080;
  localparam logic [ADDR_BITS-1:0] IRQ_ENA_ADDR = 12'h084;
  localparam logic [ADDR_BITS-1:0] IRQ_CLR_ADDR = 12'h088;

  // status byte fields, then the config threshold select bit
  localparam int unsigned STS_LOCK_BIT  = 0;
  localparam int unsigned STS_FIRST_BIT  = 1;
  localparam int unsigned STS_SECOND_BIT = 2;
  localparam int unsigned STS_OSC_BIT   = 3;
  localparam int unsigned STS_SEL_BIT   = 4;
  localparam int unsigned STS_HOLD_BIT  = 5;
  localparam int unsigned STS_CAL_BIT   = 6;
  localparam int unsigned THRESH_SEL_BIT = 6;

  // interrupt event bits
  localparam int unsigned EV_LOCK_LOST = 0;
  localparam int unsigned EV_LOCK_GOT  = 1;
  localparam int unsigned EV_REF_SWAP  = 2;
  localparam int unsigned EV_HOLD_IN   = 3;

  localparam logic [7:0]          MONCFG_RESET = 8'h00;
  localparam logic [IRQ_BITS-1:0] IRQ_RESET    = 4'h0;
  localparam logic [31:0]         ZERO_WORD    = 32'h0000_0000;
  localparam logic [1:0]          HRESP_OKAY   = 2'h0;

  typedef struct packed {
    logic cal_done;
    logic holdover;
    logic diff_mode;
    logic second_input_chosen;
    logic osc_high;
    logic second_above_hi;
    logic second_above_lo;
    logic first_above_hi;
    logic first_above_lo;
    logic lock;
  } psr_mon_type;

  localparam int unsigned MON_W = $bits(psr_mon_type);

  typedef struct packed {
    logic                 sel;
    logic [ADDR_BITS-1:0] addr;
    logic [1:0]           trans;
    logic                 write;
    logic [2:0]           size;
    logic                 ready;
  } psr_ahb_req_type;

endpackage : psr_pkg

// ==== verif/test_pll_status_readback.sv ====
// test_pll_status_readback: self-checking bench for the pll status readback block
// assumes psr_pkg and psr_top compiled first; the bench is the only AHB-Lite master
`timescale 1ns/1ps
`default_nettype none

module test_pll_status_readback;
  localparam int unsigned SYNC = 2;
  logic                 mclk;
  logic                 rst;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic [1:0]           hresp;
  logic                 threshold_select;
  logic                 irq;
  psr_pkg::psr_mon_type mon;
  int                   mismatches;
  int                   n_checks;

  // hready is the slave's own hreadyout, single-slave bus
  psr_top #(.SYNC_STAGES(SYNC)) u_dut (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .lock_detect(mon.lock),
    .first_ref_above_lo(mon.first_above_lo), .first_ref_above_hi(mon.first_above_hi),
    .second_ref_above_lo(mon.second_above_lo), .second_ref_above_hi(mon.second_above_hi),
    .osc_above_threshold(mon.osc_high), .second_input_chosen(mon.second_input_chosen),
    .differential_mode(mon.diff_mode), .holdover_active(mon.holdover),
    .calibration_done(mon.cal_done), .threshold_select(threshold_select), .irq(irq)
  );

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // no fixed latency assumed; a stuck bus counts as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    check_word("hresp", 32'h0000_0000, {30'h0000_0000, hresp});
  endtask : ahb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    check_word(what, exp, q);
  endtask : rd_chk

  // inputs pass the synchroniser, then one edge for the snapshot, plus margin
  task automatic settle();
    repeat (SYNC + 2) @(posedge mclk);
  endtask : settle

  function automatic logic [31:0] exp_status(input psr_pkg::psr_mon_type m, input logic t);
    return {24'h00_0000, 1'b0, m.cal_done, m.holdover, m.second_input_chosen & ~m.diff_mode,
            m.osc_high, t ? m.second_above_hi : m.second_above_lo,
            t ? m.first_above_hi : m.first_above_lo, m.lock};
  endfunction : exp_status

  task automatic test_reset();
    check_word("hrdata", 32'h0000_0000, hrdata);
    check_bit("irq", 1'b0, irq);
    check_bit("threshold_select", 1'b0, threshold_select);
    rd_chk("moncfg", psr_pkg::MONCFG_ADDR, 32'h0000_0000);
    rd_chk("irq_ena", psr_pkg::IRQ_ENA_ADDR, 32'h0000_0000);
    rd_chk("status", psr_pkg::STATUS_ADDR, 32'h0000_0000);
    $display("test reset done");
  endtask : test_reset

  // walking one, walking zero, all ones and all zeros under both thresholds
  task automatic test_status();
    logic [9:0] p;
    for (int t = 0; t < 2; t++) begin
      wr(psr_pkg::MONCFG_ADDR, 32'(t) << 6);
      @(posedge mclk);
      check_bit("threshold_select", t[0], threshold_select);
      rd_chk("moncfg", psr_pkg::MONCFG_ADDR, 32'(t) << 6);
      for (int i = 0; i < 22; i++) begin
        p = (i < 10) ? 10'h001 << i : (i < 20) ? ~(10'h001 << (i - 10)) : (i == 20) ? 10'h3FF : 10'h000;
        mon <= psr_pkg::psr_mon_type'(p);
        settle();
        rd_chk("status", psr_pkg::STATUS_ADDR, exp_status(mon, t[0]));
      end
    end
    $display("test status done");
  endtask : test_status

  task automatic test_ignored();
    mon <= psr_pkg::psr_mon_type'(10'h2A5);
    settle();
    wr(psr_pkg::STATUS_ADDR, 32'hFFFF_FFFF);
    rd_chk("status", psr_pkg::STATUS_ADDR, exp_status(mon, 1'b1));
    rd_chk("unmapped", 12'h200, 32'h0000_0000);
    $display("test ignored done");
  endtask : test_ignored

  // lock lost, lock gained masked then enabled, then swap and holdover together
  task automatic test_irq();
    mon <= psr_pkg::psr_mon_type'(10'h001);
    settle();
    wr(psr_pkg::IRQ_CLR_ADDR, 32'h0000_000F);
    rd_chk("irq_sts", psr_pkg::IRQ_STS_ADDR, 32'h0000_0000);
    wr(psr_pkg::IRQ_ENA_ADDR, 32'h0000_0001);
    mon <= psr_pkg::psr_mon_type'(10'h000);
    settle();
    check_bit("irq", 1'b1, irq);
    rd_chk("irq_sts", psr_pkg::IRQ_STS_ADDR, 32'h0000_0001);
    wr(psr_pkg::IRQ_CLR_ADDR, 32'h0000_0001);
    @(posedge mclk);
    check_bit("irq", 1'b0, irq);
    mon <= psr_pkg::psr_mon_type'(10'h001);
    settle();
    check_bit("irq", 1'b0, irq);
    rd_chk("irq_sts", psr_pkg::IRQ_STS_ADDR, 32'h0000_0002);
    wr(psr_pkg::IRQ_ENA_ADDR, 32'h0000_0002);
    @(posedge mclk);
    check_bit("irq", 1'b1, irq);
    wr(psr_pkg::IRQ_CLR_ADDR, 32'h0000_000F);
    mon <= psr_pkg::psr_mon_type'(10'h161);
    settle();
    rd_chk("irq_sts", psr_pkg::IRQ_STS_ADDR, 32'h0000_000C);
    wr(psr_pkg::IRQ_ENA_ADDR, 32'h0000_000F);
    @(posedge mclk);
    check_bit("irq", 1'b1, irq);
    wr(psr_pkg::IRQ_CLR_ADDR, 32'h0000_000F);
    @(posedge mclk);
    check_bit("irq", 1'b0, irq);
    $display("test irq done");
  endtask : test_irq

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // whole run is under two thousand cycles
  initial begin
    #80000;
    mismatches++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    mon = psr_pkg::psr_mon_type'(10'h000);
    mismatches = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    test_reset();
    test_status();
    test_ignored();
    test_irq();
    final_report();
  end
endmodule : test_pll_status_readback

`default_nettype wire
